// file: asr_regs.svh
// constants of the converter readout chain: timing counts and code limits
// assumes a 125 MHz system clock and a slower host-driven shift clock
//
// Operation
// - strobe rising edge starts conversion, latches mode
// - select mode drives output only while strobe or input low
// - each shift clock advances result one bit; in select mode the fall that ends the busy level shifts nothing
// - serial input low at edge picks chain
// - chain mode passes input after 16 clocks
// - serial input high at edge picks select
// - select mode: input or strobe low enables
// - select mode busy indicator on output at finish
// - result shifted most significant bit first
// - two's complement, saturating at full scale
// - conversion timed by internal clock
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

`define ASR_CLK_MHZ 125
`define ASR_CONV_TIME_NS 3200
`define ASR_CONV_CYCLES ((`ASR_CONV_TIME_NS * `ASR_CLK_MHZ) / 1000)
`define ASR_RESULT_BITS 16
`define ASR_CODE_MAX 16'h7fff
`define ASR_CODE_MIN 16'h8000
`define ASR_CONV_RST 16'h0000

`endif

// file: asr_pkg.sv
// types shared by the readout chain modules
// assumes asr_regs.svh supplies the numeric constants
package asr_pkg;
    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_CONV = 2'b01,
        ASR_DONE = 2'b10
    } asr_state_e;

    typedef enum logic {
        ASR_MODE_CHAIN = 1'b0,
        ASR_MODE_SELECT = 1'b1
    } asr_mode_e;
endpackage : asr_pkg

// file: asr_sync_if.sv
// bundle from the pin synchroniser to the readout core
// assumes all members are on the system clock
interface asr_sync_if;
    logic strobe;
    logic strobe_rise;
    logic shift_clk_fall;
    logic chain_in;

    modport src (
        output strobe,
        output strobe_rise,
        output shift_clk_fall,
        output chain_in
    );
    modport dst (
        input strobe,
        input strobe_rise,
        input shift_clk_fall,
        input chain_in
    );
endinterface : asr_sync_if

// file: asr_pin_sync.sv
// two-stage synchronisers and edge finders for the host pins
// assumes pins are asynchronous to clock and slower than a quarter of it
module asr_pin_sync (
    // system
    input wire logic clock,
    input wire logic rst,
    // pins
    input wire logic convert_strobe,
    input wire logic shift_clk,
    input wire logic serial_chain_in,
    // to core
    asr_sync_if.src sync
);
    logic [1:0] strobe_q;
    logic [1:0] sck_q;
    logic [1:0] sdi_q;
    logic strobe_prev_q;
    logic sck_prev_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strobe_q <= 2'b00;
            sck_q <= 2'b00;
            sdi_q <= 2'b00;
        end else begin
            strobe_q <= {strobe_q[0], convert_strobe};
            sck_q <= {sck_q[0], shift_clk};
            sdi_q <= {sdi_q[0], serial_chain_in};
        end
    end

    // edge detection only on the second stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strobe_prev_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            strobe_prev_q <= strobe_q[1];
            sck_prev_q <= sck_q[1];
        end
    end

    assign sync.strobe = strobe_q[1];
    assign sync.strobe_rise = strobe_q[1] & ~strobe_prev_q;
    assign sync.shift_clk_fall = ~sck_q[1] & sck_prev_q;
    assign sync.chain_in = sdi_q[1];
endmodule : asr_pin_sync

// file: asr_readout.sv
// conversion start, mode capture and serial readout of a 16-bit converter
// assumes the host drives strobe, shift clock and chain input; the analog
// result arrives as a signed sample with an over/under range flag pair
`include "asr_regs.svh"
module asr_readout (
    // system
    input wire logic clock,
    input wire logic rst,
    // host pins
    input wire logic convert_strobe,
    input wire logic shift_clk,
    input wire logic serial_chain_in,
    // sampled analog value from the front end
    input wire logic [15:0] sample_code,
    input wire logic sample_over,
    input wire logic sample_under,
    // serial output, three-state
    output logic serial_result_out,
    output logic serial_result_oe,
    // status
    output logic converting
);
    //**********************************************************
    // pin synchronisation
    //**********************************************************
    asr_sync_if sync ();

    asr_pin_sync u_sync (
        .clock(clock),
        .rst(rst),
        .convert_strobe(convert_strobe),
        .shift_clk(shift_clk),
        .serial_chain_in(serial_chain_in),
        .sync(sync.src)
    );

    //**********************************************************
    // conversion timing
    //**********************************************************
    localparam int CONV_CYC = `ASR_CONV_CYCLES;

    asr_pkg::asr_state_e state_q;
    asr_pkg::asr_mode_e mode_q;
    logic [15:0] conv_cnt_q;
    logic [15:0] result_q;
    logic [15:0] shift_q;
    logic [4:0] bit_cnt_q;
    logic busy_q;
    logic sdo_q;
    logic oe_q;
    logic conv_q;
    logic conv_end;
    logic [15:0] code_sat;
    logic sel_low;

    // sampling happens at the strobe edge; the chain mode decision uses
    // the synchronised input level at that same edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= asr_pkg::ASR_MODE_SELECT;
        end else if (sync.strobe_rise && state_q != asr_pkg::ASR_CONV) begin
            // a rise during a conversion is ignored, so the mode stays put
            mode_q <= sync.chain_in ? asr_pkg::ASR_MODE_SELECT : asr_pkg::ASR_MODE_CHAIN;
        end
    end

    // internal clock only; shift clock is not needed while converting
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= asr_pkg::ASR_IDLE;
            conv_cnt_q <= 16'h0000;
        end else begin
            unique case (state_q)
                asr_pkg::ASR_IDLE: begin
                    if (sync.strobe_rise) begin
                        state_q <= asr_pkg::ASR_CONV;
                        conv_cnt_q <= 16'h0000;
                    end
                end
                asr_pkg::ASR_CONV: begin
                    if (conv_end) begin
                        state_q <= asr_pkg::ASR_DONE;
                    end else begin
                        conv_cnt_q <= conv_cnt_q + 16'h0001;
                    end
                end
                asr_pkg::ASR_DONE: begin
                    if (sync.strobe_rise) begin
                        state_q <= asr_pkg::ASR_CONV;
                        conv_cnt_q <= 16'h0000;
                    end
                end
                default: begin
                    state_q <= asr_pkg::ASR_IDLE;
                end
            endcase
        end
    end

    // the host must allow the full time before reading
    assign conv_end = (state_q == asr_pkg::ASR_CONV) && (conv_cnt_q == 16'(CONV_CYC - 1));

    //**********************************************************
    // result coding
    //**********************************************************
    always_comb begin
        if (sample_over) begin
            code_sat = `ASR_CODE_MAX;
        end else if (sample_under) begin
            code_sat = `ASR_CODE_MIN;
        end else begin
            code_sat = sample_code;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result_q <= `ASR_CONV_RST;
        end else if (sync.strobe_rise && state_q != asr_pkg::ASR_CONV) begin
            result_q <= code_sat;
        end
    end

    //**********************************************************
    // serial output
    //**********************************************************
    assign sel_low = ~sync.strobe | ~sync.chain_in;

    // shift register: msb first; in chain mode the input fills from the
    // bottom so it reaches the output after 16 shift clocks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift_q <= 16'h0000;
            bit_cnt_q <= 5'h00;
        end else if (conv_end) begin
            shift_q <= result_q;
            bit_cnt_q <= 5'h00;
        end else if (sync.shift_clk_fall && state_q == asr_pkg::ASR_DONE) begin
            if (mode_q == asr_pkg::ASR_MODE_CHAIN) begin
                shift_q <= {shift_q[14:0], sync.chain_in};
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end else if (sel_low && !busy_q && bit_cnt_q != 5'h10) begin
                // the fall that ends the busy level shifts nothing
                shift_q <= {shift_q[14:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // busy indicator: armed when selected as the conversion ends
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else if (conv_end && mode_q == asr_pkg::ASR_MODE_SELECT && sel_low) begin
            // set wins over a clear in the same cycle
            busy_q <= 1'b1;
        end else if (sync.strobe_rise) begin
            busy_q <= 1'b0;
        end else if (sync.shift_clk_fall) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (mode_q == asr_pkg::ASR_MODE_SELECT) begin
            // low during conversion, high from its end until the first shift clock when busy
            sdo_q <= (state_q == asr_pkg::ASR_DONE) ? (busy_q | shift_q[15]) : 1'b0;
            oe_q <= sel_low && !(state_q == asr_pkg::ASR_DONE && bit_cnt_q == 5'h10);
        end else begin
            // chain: host reads with strobe high so always driven
            sdo_q <= shift_q[15];
            oe_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            conv_q <= 1'b0;
        end else begin
            conv_q <= (state_q == asr_pkg::ASR_CONV) && !conv_end;
        end
    end

    assign serial_result_out = sdo_q;
    assign serial_result_oe = oe_q;
    assign converting = conv_q;
endmodule : asr_readout

// file: asr_host_model.sv
// host model: strobe, shift clock and chain input of the converter
// assumes tasks are entered 1 ns after a system clock edge
module asr_host_model (
    // pins
    output logic convert_strobe,
    output logic shift_clk,
    output logic serial_chain_in,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    // captured word
    output logic [15:0] rx_word,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // pin sequences
    // ****************
    logic line;
    // a released line reads as the inverse of its last level
    assign line = serial_result_oe ? serial_result_out : !serial_result_out;
    initial begin
        convert_strobe = 1'b0;
        shift_clk = 1'b0;
        serial_chain_in = 1'b1;
        rx_word = 16'h0000;
        rx_valid = 1'b0;
    end
    task automatic start(input logic sel, input logic busy);
        convert_strobe = 1'b0;
        serial_chain_in = sel;
        #64 convert_strobe = 1'b1;
        #64 serial_chain_in = 1'b1;
        convert_strobe = !busy;
        #3600 convert_strobe = !sel;
    endtask : start
    // one clock for the busy level that leads the word when armed
    task automatic read_busy();
        #32 shift_clk = 1'b1;
        #24 rx_word = {15'h0000, line};
        #8 shift_clk = 1'b0;
        rx_valid = 1'b1;
        #8 rx_valid = 1'b0;
    endtask : read_busy
    // chain input moves 32 ns away from each fall so its sync path never races the clock
    task automatic read_word(input logic [15:0] feed);
        for (int i = 15; i >= 0; i--) begin
            #32 shift_clk = 1'b1;
            serial_chain_in = feed[i];
            #24 rx_word[i] = line;
            #8 shift_clk = 1'b0;
        end
        rx_valid = 1'b1;
        #8 rx_valid = 1'b0;
    endtask : read_word
endmodule : asr_host_model

// file: asr_readout_sva.sv
// checker for the pins of asr_readout
// assumes the host holds the mode level steady around each strobe rise
module asr_readout_sva (
    // system
    input wire logic clock,
    input wire logic rst,
    // pins
    input wire logic convert_strobe,
    input wire logic shift_clk,
    input wire logic serial_chain_in,
    input wire logic sample_under,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic converting
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // helper state
    // ****************
    logic chain_q;
    logic conv_p_q;
    logic sck_p_q;
    logic strb_p_q;
    logic [8:0] len_q;
    logic [4:0] falls_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chain_q <= 1'b0;
            conv_p_q <= 1'b0;
            sck_p_q <= 1'b0;
            strb_p_q <= 1'b0;
            len_q <= 9'h000;
            falls_q <= 5'h00;
        end else begin
            conv_p_q <= converting;
            sck_p_q <= shift_clk;
            strb_p_q <= convert_strobe;
            len_q <= converting ? len_q + 9'h001 : 9'h000;
            if (converting && !conv_p_q) begin
                chain_q <= !serial_chain_in;
            end
            // count from the strobe rise; an armed busy level costs one extra fall
            if (convert_strobe && !strb_p_q) begin
                falls_q <= 5'h00;
            end else if (conv_p_q && !converting) begin
                falls_q <= (convert_strobe && serial_chain_in) ? 5'h00 : 5'h1f;
            end else if (sck_p_q && !shift_clk) begin
                falls_q <= falls_q + 5'h01;
            end
        end
    end
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_start;
        $rose(convert_strobe) && !converting |-> ##[2:6] converting;
    endproperty
    a_start: assert property (p_start) else $error("no conversion after strobe rise");
    // no slack below the 399-cycle length, up to two cycles above it for the edge detector
    property p_len;
        $fell(converting) |-> len_q inside {[9'h18f:9'h191]};
    endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_chain;
        chain_q && !converting |-> serial_result_oe;
    endproperty
    a_chain: assert property (p_chain) else $error("chain output not driven");
    property p_sel_off;
        (!chain_q && convert_strobe && serial_chain_in) [*8] |-> !serial_result_oe;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("output driven while deselected");
    property p_sel_en;
        $fell(convert_strobe) && !chain_q && !converting |-> ##[2:7] serial_result_oe;
    endproperty
    a_sel_en: assert property (p_sel_en) else $error("low strobe did not enable output");
    property p_busy;
        converting && serial_result_oe && !chain_q |-> !serial_result_out;
    endproperty
    a_busy: assert property (p_busy) else $error("busy level wrong");
    property p_busy_hi;
        $fell(converting) && !chain_q && serial_result_oe |-> ##[1:3] serial_result_out;
    endproperty
    a_busy_hi: assert property (p_busy_hi) else $error("busy level not raised at conversion end");
    property p_release;
        (!chain_q && falls_q == 5'h10) [*8] |-> !serial_result_oe;
    endproperty
    a_release: assert property (p_release) else $error("output held after last bit");
    property p_under;
        $fell(converting) && chain_q && sample_under |-> ##[1:4] serial_result_out;
    endproperty
    a_under: assert property (p_under) else $error("underrange first bit low");
endmodule : asr_readout_sva

// file: tb_top.sv
// testbench: six frames over both modes, saturation and busy indicator
// assumes asr_host_model plays the host; the checker is bound here
bind asr_readout asr_readout_sva asr_readout_sva_inst (.clock(clock), .rst(rst), .convert_strobe(convert_strobe),
    .shift_clk(shift_clk), .serial_chain_in(serial_chain_in), .sample_under(sample_under),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe), .converting(converting));
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // signals and instances
    // ****************
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic convert_strobe;
    logic shift_clk;
    logic serial_chain_in;
    logic [15:0] sample_code = 16'h0000;
    logic sample_over = 1'b0;
    logic sample_under = 1'b0;
    logic serial_result_out;
    logic serial_result_oe;
    logic converting;
    logic [15:0] rx_word;
    logic rx_valid;
    logic [15:0] exp_q[$];
    int fail_count = 0;
    int checked = 0;
    always #4 clock = !clock;
    asr_readout asr_readout_inst (.clock(clock), .rst(rst), .convert_strobe(convert_strobe),
        .shift_clk(shift_clk), .serial_chain_in(serial_chain_in), .sample_code(sample_code),
        .sample_over(sample_over), .sample_under(sample_under), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe), .converting(converting));
    asr_host_model asr_host_model_inst (.convert_strobe(convert_strobe), .shift_clk(shift_clk),
        .serial_chain_in(serial_chain_in), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe), .rx_word(rx_word), .rx_valid(rx_valid));
    // ****************
    // checking and verdict
    // ****************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, want, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge rx_valid) begin
        if (exp_q.size() == 0) begin
            fail_count++;
            $display("mismatch queue expected a note seen none");
        end else begin
            check("word", rx_word, exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        $display("mismatch timeout expected end of frames seen cycle limit");
        complete_run();
    end
    // ****************
    // frames: chain, select, chain under, select over, select busy, chain
    // ****************
    initial begin
        logic [15:0] code;
        logic [15:0] feed;
        logic sel;
        void'($urandom(32'h2fac));
        repeat (10) @(posedge clock);
        #1 rst = 1'b0;
        for (int k = 0; k < 6; k++) begin
            code = 16'($urandom());
            feed = 16'($urandom());
            sel = k inside {1, 3, 4};
            sample_code = code;
            sample_under = (k == 2);
            sample_over = (k == 3);
            if (k == 4) begin
                exp_q.push_back(16'h0001);
            end
            exp_q.push_back(k == 2 ? 16'h8000 : (k == 3 ? 16'h7fff : code));
            asr_host_model_inst.start(sel, k == 4);
            if (k == 4) begin
                asr_host_model_inst.read_busy();
            end
            asr_host_model_inst.read_word(feed);
            if (!sel) begin
                exp_q.push_back(feed);
                asr_host_model_inst.read_word(16'h0000);
            end
        end
        #104;
        if (exp_q.size() != 0) begin
            fail_count++;
            $display("mismatch queue expected 0 notes seen %0d", exp_q.size());
        end
        complete_run();
    end
endmodule : tb_top
